// file: include/touch_pkg.sv
// Shared constants and types for the touch report framer.
// Assumes a single system clock; included ahead of every design file.
package touch_pkg;

  // Touch record layout
  localparam int MAX_TOUCH = 10;
  localparam int REC_BYTES = 6;
  localparam logic [5:0] REC_AREA_LAST = 6'd59;
  localparam logic [3:0] REC_BYTE_LAST = 4'd5;
  localparam int IN_RANGE_BIT = 1;
  localparam int TOUCH_STATE_BIT = 0;

  // USB reports
  localparam logic [7:0] DIG_REPORT_ID = 8'h01;
  localparam logic [7:0] GEN_REPORT_ID = 8'h05;
  localparam logic [5:0] DIG_ID_BYTE = 6'd0;
  localparam logic [5:0] DIG_LAST_REC_BYTE = 6'd52;
  localparam logic [5:0] DIG_COUNT_BYTE = 6'd53;
  localparam logic [1:0] EP_DIGITIZER = 2'd1;
  localparam logic [1:0] EP_GENERIC = 2'd2;

  // I2C target and map
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h25;
  localparam logic [7:0] I2C_STATUS_ADDR = 8'h00;
  localparam logic [7:0] I2C_REC_LAST_ADDR = 8'h3c;
  localparam logic [7:0] I2C_STREAM_ADDR = 8'h40;
  localparam int STATUS_STR_BIT = 4;

  // Strap level that selects I2C
  localparam logic STRAP_I2C = 1'b1;

  typedef enum logic {MODE_USB, MODE_I2C} host_mode_e;

  typedef struct packed {
    logic in_range_flag;
    logic touch_state_flag;
    logic [7:0] id;
    logic [15:0] x;
    logic [15:0] y;
  } contact_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [1:0] ep;
  } usb_byte_s;

endpackage : touch_pkg

// file: design/report_mem.sv
// Byte memory holding the touch records of the latest snapshot.
// One write port, one read port; read data come from a register.
`timescale 1ns/10ps
module report_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : report_mem

// file: design/touch_report_framer.sv
// Touch report framer: strap-selected USB or I2C reporting front end.
// Assumes byte-level USB endpoint and I2C target engines outside.
`timescale 1ns/10ps
module touch_report_framer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_interface_select_strap,
  input wire touch_pkg::contact_s [touch_pkg::MAX_TOUCH-1:0] i_contacts,
  input wire logic [3:0] i_count,
  input wire logic i_snap_valid,
  output logic o_snap_ready,
  output logic o_mode_valid,
  output logic o_mode_i2c,
  output touch_pkg::usb_byte_s o_usb_tx,
  output logic o_usb_tx_valid,
  input wire logic i_usb_tx_ready,
  input wire logic [7:0] i_msg_data,
  input wire logic i_msg_last,
  input wire logic i_msg_valid,
  output logic o_msg_ready,
  input wire logic i_out_pkt,
  input wire logic [5:0] i_out_pkt_num,
  output logic [5:0] o_out_pkt_num,
  output logic o_out_pkt_err,
  input wire logic i_i2c_start,
  input wire logic [7:0] i_i2c_byte,
  input wire logic i_i2c_wr,
  input wire logic i_i2c_rd,
  output logic o_i2c_ack,
  output logic [7:0] o_i2c_rd_data,
  output logic o_i2c_rd_valid,
  output logic [7:0] o_stream_wr_data,
  output logic o_stream_wr_valid
);
  import touch_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOAD, ST_DIG_RD, ST_DIG_LD, ST_DIG_TX,
    ST_GEN_ID, ST_GEN_NUM, ST_GEN_WAIT, ST_GEN_PAY
  } frame_state_e;

  frame_state_e state_r;
  host_mode_e mode_r;
  logic mode_done_r;
  contact_s [MAX_TOUCH-1:0] snap_r;
  logic [3:0] count_r;
  logic [3:0] rec_r, rbyte_r;
  logic [5:0] widx_r, ridx_r;
  logic [5:0] in_pkt_num_r, out_pkt_num_r;
  usb_byte_s tx_r;
  logic [7:0] wbyte;
  logic [5:0] raddr;
  logic [7:0] rdata;
  logic usb_mode, i2c_mode, tx_fire, addr_hit;
  logic i2c_active_r, i2c_read_r, i2c_ptr_phase_r;
  logic [7:0] ptr_r, ptr_m1;
  logic rd_pend_r;
  logic [7:0] rd_addr_r, msg_hold_r;
  logic stream_rd;

  assign usb_mode = mode_done_r && (mode_r == MODE_USB);
  assign i2c_mode = mode_done_r && (mode_r == MODE_I2C);
  assign o_mode_valid = mode_done_r;
  assign o_mode_i2c = (mode_r == MODE_I2C);
  assign o_snap_ready = mode_done_r && (state_r == ST_IDLE);
  assign o_usb_tx = tx_r;
  assign ptr_m1 = ptr_r - 8'h01;

  // Strap caught once after reset release, then frozen
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_r <= MODE_USB;
      mode_done_r <= 1'b0;
    end else if (!mode_done_r) begin
      mode_r <= (i_interface_select_strap == STRAP_I2C) ? MODE_I2C : MODE_USB;
      mode_done_r <= 1'b1;
    end
  end

  // Record byte for the loader; zero past the valid count
  always_comb begin
    wbyte = '0;
    if (rec_r < count_r) begin
      case (rbyte_r)
        4'd0: wbyte = {6'h00, snap_r[rec_r].in_range_flag,
                       snap_r[rec_r].touch_state_flag};
        4'd1: wbyte = snap_r[rec_r].id;
        4'd2: wbyte = snap_r[rec_r].x[7:0];
        4'd3: wbyte = snap_r[rec_r].x[15:8];
        4'd4: wbyte = snap_r[rec_r].y[7:0];
        4'd5: wbyte = snap_r[rec_r].y[15:8];
        default: wbyte = '0;
      endcase
    end
  end

  // Shared read address: report byte index or I2C pointer
  assign raddr = i2c_mode ? ptr_m1[5:0] : (ridx_r - 6'd1);

  report_mem #(.AW(6), .DW(8)) u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(state_r == ST_LOAD),
    .i_waddr(widx_r),
    .i_wdata(wbyte),
    .i_raddr(raddr),
    .o_rdata(rdata)
  );

  // USB byte handshake
  assign o_usb_tx_valid = (state_r == ST_DIG_TX) || (state_r == ST_GEN_ID) ||
                          (state_r == ST_GEN_NUM) || (state_r == ST_GEN_PAY);
  assign tx_fire = o_usb_tx_valid && i_usb_tx_ready;

  // Message bytes taken by a USB generic packet or an I2C stream read
  assign stream_rd = i2c_mode && i2c_active_r && i2c_read_r && i_i2c_rd &&
                     (ptr_r == I2C_STREAM_ADDR);
  assign o_msg_ready = (usb_mode && state_r == ST_GEN_WAIT) || stream_rd;

  // Snapshot capture, record loading and USB framing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      snap_r <= '0;
      count_r <= '0;
      rec_r <= '0;
      rbyte_r <= '0;
      widx_r <= '0;
      ridx_r <= '0;
      tx_r <= '0;
      in_pkt_num_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (o_snap_ready && i_snap_valid) begin
            snap_r <= i_contacts;
            count_r <= (i_count > 4'(MAX_TOUCH)) ? 4'(MAX_TOUCH) : i_count;
            rec_r <= '0;
            rbyte_r <= '0;
            widx_r <= '0;
            state_r <= ST_LOAD;
          end else if (usb_mode && i_msg_valid) begin
            tx_r <= '{data: GEN_REPORT_ID, last: 1'b0, ep: EP_GENERIC};
            state_r <= ST_GEN_ID;
          end
        end
        ST_LOAD: begin
          widx_r <= widx_r + 6'd1;
          if (rbyte_r == REC_BYTE_LAST) begin
            rbyte_r <= '0;
            rec_r <= rec_r + 4'd1;
          end else begin
            rbyte_r <= rbyte_r + 4'd1;
          end
          if (widx_r == REC_AREA_LAST) begin
            ridx_r <= DIG_ID_BYTE;
            state_r <= usb_mode ? ST_DIG_RD : ST_IDLE;
          end
        end
        ST_DIG_RD: state_r <= ST_DIG_LD; // Memory read latency
        ST_DIG_LD: begin
          tx_r.ep <= EP_DIGITIZER;
          tx_r.last <= (ridx_r == DIG_COUNT_BYTE);
          if (ridx_r == DIG_ID_BYTE) begin
            tx_r.data <= DIG_REPORT_ID;
          end else if (ridx_r == DIG_COUNT_BYTE) begin
            tx_r.data <= {4'h0, count_r};
          end else begin
            tx_r.data <= rdata;
          end
          state_r <= ST_DIG_TX;
        end
        ST_DIG_TX: begin
          if (tx_fire) begin
            ridx_r <= ridx_r + 6'd1;
            state_r <= (ridx_r == DIG_COUNT_BYTE) ? ST_IDLE : ST_DIG_RD;
          end
        end
        ST_GEN_ID: begin
          if (tx_fire) begin
            tx_r.data <= {2'b00, in_pkt_num_r};
            state_r <= ST_GEN_NUM;
          end
        end
        ST_GEN_NUM: begin
          if (tx_fire) begin
            state_r <= ST_GEN_WAIT;
          end
        end
        ST_GEN_WAIT: begin
          if (i_msg_valid) begin
            tx_r.data <= i_msg_data;
            tx_r.last <= i_msg_last;
            state_r <= ST_GEN_PAY;
          end
        end
        ST_GEN_PAY: begin
          if (tx_fire) begin
            if (tx_r.last) begin
              in_pkt_num_r <= in_pkt_num_r + 6'd1;
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_GEN_WAIT;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // OUT packet sequence check, independent of the IN counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_pkt_num_r <= '0;
      o_out_pkt_err <= 1'b0;
    end else if (usb_mode && i_out_pkt) begin
      o_out_pkt_err <= (i_out_pkt_num != out_pkt_num_r);
      out_pkt_num_r <= i_out_pkt_num + 6'd1;
    end
  end
  assign o_out_pkt_num = out_pkt_num_r;

  // I2C addressing and pointer auto-increment
  assign addr_hit = (i_i2c_byte[7:1] == I2C_TARGET_ADDR);
  assign o_i2c_ack = i2c_mode && i_i2c_start && addr_hit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      i2c_active_r <= 1'b0;
      i2c_read_r <= 1'b0;
      i2c_ptr_phase_r <= 1'b0;
      ptr_r <= '0;
      o_stream_wr_data <= '0;
      o_stream_wr_valid <= 1'b0;
    end else begin
      o_stream_wr_valid <= 1'b0;
      if (i2c_mode && i_i2c_start) begin
        i2c_active_r <= addr_hit;
        i2c_read_r <= i_i2c_byte[0];
        i2c_ptr_phase_r <= ~i_i2c_byte[0];
      end else if (i2c_active_r && !i2c_read_r && i_i2c_wr) begin
        if (i2c_ptr_phase_r) begin
          ptr_r <= i_i2c_byte;
          i2c_ptr_phase_r <= 1'b0;
        end else begin
          if (ptr_r == I2C_STREAM_ADDR) begin
            o_stream_wr_data <= i_i2c_byte;
            o_stream_wr_valid <= 1'b1;
          end
          ptr_r <= ptr_r + 8'h01;
        end
      end else if (i2c_active_r && i2c_read_r && i_i2c_rd) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // I2C read data: status, records, stream buffer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      msg_hold_r <= '0;
      o_i2c_rd_data <= '0;
      o_i2c_rd_valid <= 1'b0;
    end else begin
      rd_pend_r <= i2c_mode && i2c_active_r && i2c_read_r && i_i2c_rd;
      rd_addr_r <= ptr_r;
      msg_hold_r <= (stream_rd && i_msg_valid) ? i_msg_data : 8'h00;
      o_i2c_rd_valid <= rd_pend_r;
      if (rd_pend_r) begin
        if (rd_addr_r == I2C_STATUS_ADDR) begin
          o_i2c_rd_data <= {3'b000, i_msg_valid, count_r};
          o_i2c_rd_data[STATUS_STR_BIT] <= i_msg_valid;
        end else if (rd_addr_r <= I2C_REC_LAST_ADDR) begin
          o_i2c_rd_data <= rdata;
        end else if (rd_addr_r == I2C_STREAM_ADDR) begin
          o_i2c_rd_data <= msg_hold_r;
        end else begin
          o_i2c_rd_data <= 8'h00;
        end
      end
    end
  end
endmodule : touch_report_framer

// file: verif/touch_report_framer_properties.sv
// Port checks for the touch report framer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module touch_report_framer_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_interface_select_strap,
  input wire logic o_snap_ready,
  input wire logic o_mode_valid,
  input wire logic o_mode_i2c,
  input wire touch_pkg::usb_byte_s o_usb_tx,
  input wire logic o_usb_tx_valid,
  input wire logic i_usb_tx_ready,
  input wire logic i_out_pkt,
  input wire logic [5:0] i_out_pkt_num,
  input wire logic [5:0] o_out_pkt_num,
  input wire logic o_out_pkt_err,
  input wire logic i_i2c_start,
  input wire logic [7:0] i_i2c_byte,
  input wire logic i_i2c_wr,
  input wire logic i_i2c_rd,
  input wire logic o_i2c_ack,
  input wire logic o_i2c_rd_valid,
  input wire logic o_stream_wr_valid
);
  import touch_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Mode selection and its hold
  mode_hold_a: assert property (o_mode_valid && $past(o_mode_valid) |-> $stable(o_mode_i2c))
    else $error("host mode changed");
  strap_pick_a: assert property ($rose(o_mode_valid) |->
    o_mode_i2c == ($past(i_interface_select_strap) == STRAP_I2C)) else $error("bad mode");
  snap_gate_a: assert property (o_snap_ready |-> o_mode_valid)
    else $error("ready before mode");
  // USB byte stream
  usb_only_a: assert property (o_usb_tx_valid |-> o_mode_valid && !o_mode_i2c)
    else $error("usb byte in i2c mode");
  tx_hold_a: assert property (o_usb_tx_valid && !i_usb_tx_ready |=>
    o_usb_tx_valid && $stable(o_usb_tx)) else $error("usb byte dropped");
  count_max_a: assert property (o_usb_tx_valid && o_usb_tx.last &&
    o_usb_tx.ep == EP_DIGITIZER |-> o_usb_tx.data <= 8'h0a) else $error("count too big");
  out_num_a: assert property (i_out_pkt && o_mode_valid && !o_mode_i2c |=>
    o_out_pkt_num == $past(i_out_pkt_num) + 6'h01 &&
    o_out_pkt_err == ($past(i_out_pkt_num) != $past(o_out_pkt_num))) else $error("out number");
  // I2C target side
  ack_match_a: assert property (i_i2c_start && o_mode_i2c &&
    i_i2c_byte[7:1] == I2C_TARGET_ADDR |-> o_i2c_ack) else $error("missing ack");
  ack_only_a: assert property (o_i2c_ack |-> i_i2c_start && o_mode_i2c &&
    i_i2c_byte[7:1] == I2C_TARGET_ADDR) else $error("stray ack");
  rd_lat_a: assert property (o_i2c_rd_valid |-> $past(i_i2c_rd) || $past(i_i2c_rd, 2))
    else $error("stray read data");
  stream_wr_a: assert property (o_stream_wr_valid |-> $past(i_i2c_wr))
    else $error("stray stream write");
endmodule : touch_report_framer_properties
bind touch_report_framer touch_report_framer_properties chk (.i_clk, .i_rst,
  .i_interface_select_strap, .o_snap_ready, .o_mode_valid, .o_mode_i2c, .o_usb_tx,
  .o_usb_tx_valid, .i_usb_tx_ready, .i_out_pkt, .i_out_pkt_num, .o_out_pkt_num, .o_out_pkt_err,
  .i_i2c_start, .i_i2c_byte, .i_i2c_wr, .i_i2c_rd, .o_i2c_ack, .o_i2c_rd_valid,
  .o_stream_wr_valid);

// file: verif/usb_sink_model.sv
// Endpoint engine model taking USB bytes from the framer.
// Assumes each byte is held until ready is seen high.
`timescale 1ns/10ps
module usb_sink_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire touch_pkg::usb_byte_s i_tx,
  input wire logic i_tx_valid,
  output logic o_ready
);
  import touch_pkg::*;
  usb_byte_s got[$];
  logic phase_r = 1'b0;
  initial o_ready = 1'b0;
  // Stalls every other cycle when slow
  always @(posedge i_clk) begin
    phase_r <= ~phase_r;
    o_ready <= ~i_slow | phase_r;
    if (i_tx_valid && o_ready) got.push_back(i_tx);
  end
endmodule : usb_sink_model

// file: verif/tb_touch_report_framer.sv
// Bench for the touch report framer in USB and I2C modes.
// Assumes usb_sink_model as endpoint engine and the bound checker.
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_touch_report_framer;
  import touch_pkg::*;
  logic i_clk = 0, i_rst = 1, strap = 0, snap_v = 0, slow = 0, op = 0, st = 0, iw = 0;
  logic rq = 0, mv = 0, mlast = 0, snap_rdy, mode_v, mode_i2c, tx_v, tx_rdy, m_rdy;
  logic oerr, ack, rdv, swv;
  contact_s [MAX_TOUCH-1:0] cts;
  logic [3:0] cnt = 0;
  logic [7:0] md = 0, ib = 0, rdd, swd;
  logic [5:0] os = 0, onum, oe = 0;
  usb_byte_s tx;
  int fails = 0, checked = 0, mi = 0, ml = 0, k;
  // Design and endpoint model
  touch_report_framer uut (.i_clk, .i_rst, .i_interface_select_strap(strap),
    .i_contacts(cts), .i_count(cnt), .i_snap_valid(snap_v), .o_snap_ready(snap_rdy),
    .o_mode_valid(mode_v), .o_mode_i2c(mode_i2c), .o_usb_tx(tx), .o_usb_tx_valid(tx_v),
    .i_usb_tx_ready(tx_rdy), .i_msg_data(md), .i_msg_last(mlast), .i_msg_valid(mv),
    .o_msg_ready(m_rdy), .i_out_pkt(op), .i_out_pkt_num(os), .o_out_pkt_num(onum),
    .o_out_pkt_err(oerr), .i_i2c_start(st), .i_i2c_byte(ib), .i_i2c_wr(iw), .i_i2c_rd(rq),
    .o_i2c_ack(ack), .o_i2c_rd_data(rdd), .o_i2c_rd_valid(rdv), .o_stream_wr_data(swd),
    .o_stream_wr_valid(swv));
  usb_sink_model sink (.i_clk, .i_slow(slow), .i_tx(tx), .i_tx_valid(tx_v), .o_ready(tx_rdy));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // Message source, one byte per accept
  always @(posedge i_clk) begin
    if (mv && m_rdy) begin
      mi <= mi + 1;
      md <= md + 8'h01;
      mlast <= (mi + 2 == ml);
      if (mlast) mv <= 1'b0;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic lim(input int n);
    if (k >= n) begin
      fails++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
    end
  endtask : lim
  function automatic logic [7:0] rb(input int n, input logic [3:0] c);
    contact_s t;
    t = cts[n / 6];
    if (n / 6 >= c) return 8'h00;
    case (n % 6)
      0: return {6'h00, t.in_range_flag, t.touch_state_flag};
      1: return t.id;
      2: return t.x[7:0];
      3: return t.x[15:8];
      4: return t.y[7:0];
      default: return t.y[15:8];
    endcase
  endfunction : rb
  task automatic rst_to(input logic s);
    @(posedge i_clk);
    i_rst <= 1'b1;
    strap <= s;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : rst_to
  task automatic idle;
    @(negedge i_clk);
    for (k = 0; k < 900 && snap_rdy !== 1'b1; k++) @(negedge i_clk);
    lim(900);
  endtask : idle
  task automatic snap(input logic [3:0] c);
    @(posedge i_clk);
    cnt <= c;
    snap_v <= 1'b1;
    idle();
    @(posedge i_clk);
    snap_v <= 1'b0;
  endtask : snap
  task automatic chk_dig(input logic [3:0] c);
    for (k = 0; k < 900 && sink.got.size() < 54; k++) @(negedge i_clk);
    lim(900);
    for (int i = 0; i < 54; i++) begin
      `CHK(sink.got[i].data, i == 0 ? DIG_REPORT_ID : i == 53 ? {4'h0, c} : rb(i - 1, c))
      `CHK(sink.got[i].ep, EP_DIGITIZER)
      `CHK(sink.got[i].last, i == 53)
    end
    sink.got.delete();
  endtask : chk_dig
  task automatic gen(input int n, input logic [5:0] s);
    @(posedge i_clk);
    ml <= n;
    mi <= 0;
    md <= 8'ha0;
    mlast <= (n == 1);
    mv <= 1'b1;
    for (k = 0; k < 900 && sink.got.size() < n + 2; k++) @(negedge i_clk);
    lim(900);
    `CHK(sink.got[0].data, GEN_REPORT_ID)
    `CHK(sink.got[1].data, {2'b00, s})
    for (int i = 0; i < n + 2; i++) begin
      `CHK(sink.got[i].ep, EP_GENERIC)
      `CHK(sink.got[i].last, i == n + 1)
      if (i > 1) `CHK(sink.got[i].data, 8'ha0 + 8'(i - 2))
    end
    sink.got.delete();
  endtask : gen
  task automatic outp(input logic [5:0] s);
    @(posedge i_clk);
    op <= 1'b1;
    os <= s;
    @(posedge i_clk);
    op <= 1'b0;
    @(negedge i_clk);
    `CHK(onum, s + 6'h01)
    `CHK(oerr, s != oe)
    oe = s + 6'h01;
  endtask : outp
  task automatic i2c_start(input logic [7:0] b, input logic a);
    @(posedge i_clk);
    st <= 1'b1;
    ib <= b;
    @(negedge i_clk);
    `CHK(ack, a)
    @(posedge i_clk);
    st <= 1'b0;
  endtask : i2c_start
  task automatic i2c_wr(input logic [7:0] b);
    @(posedge i_clk);
    iw <= 1'b1;
    ib <= b;
    @(posedge i_clk);
    iw <= 1'b0;
  endtask : i2c_wr
  task automatic i2c_rd(input logic [7:0] e);
    @(posedge i_clk);
    rq <= 1'b1;
    @(posedge i_clk);
    rq <= 1'b0;
    @(negedge i_clk);
    for (k = 0; k < 4 && rdv !== 1'b1; k++) @(negedge i_clk);
    lim(4);
    `CHK(rdd, e)
  endtask : i2c_rd
  // Main sequence: USB mode, then I2C mode after a second reset
  initial begin
    for (int i = 0; i < MAX_TOUCH; i++) begin
      cts[i] = '{1'b1, i[0], 8'h10 + 8'(i), 16'h1200 + 16'(i), 16'h3400 + 16'(i)};
    end
    rst_to(1'b0);
    `CHK(mode_i2c, 1'b0)
    `CHK(mode_v, 1'b1)
    slow <= 1'b1;
    snap(4'd3);
    chk_dig(4'd3);
    strap <= 1'b1;
    slow <= 1'b0;
    snap(4'hf);
    chk_dig(4'd10);
    `CHK(mode_i2c, 1'b0)
    $display("test usb digitizer done");
    gen(3, 6'h00);
    gen(1, 6'h01);
    outp(6'h05);
    outp(6'h06);
    outp(6'h3f);
    outp(6'h00);
    $display("test usb generic done");
    rst_to(1'b1);
    `CHK(mode_i2c, 1'b1)
    snap(4'd4);
    idle();
    i2c_start(8'h4c, 1'b0);
    i2c_start(8'h4a, 1'b1);
    i2c_wr(I2C_STATUS_ADDR);
    i2c_start(8'h4b, 1'b1);
    i2c_rd(8'h04);
    for (int j = 0; j < 8; j++) i2c_rd(rb(j, 4'd4));
    i2c_start(8'h4a, 1'b1);
    i2c_wr(8'h19);
    i2c_start(8'h4b, 1'b1);
    i2c_rd(8'h00);
    i2c_start(8'h4a, 1'b1);
    i2c_wr(I2C_STREAM_ADDR);
    i2c_wr(8'h77);
    for (k = 0; k < 4 && swv !== 1'b1; k++) @(negedge i_clk);
    lim(4);
    `CHK(swd, 8'h77)
    // Stream flag in status, then one byte popped at the stream address
    i2c_start(8'h4a, 1'b1);
    i2c_wr(I2C_STATUS_ADDR);
    ml <= 1;
    mi <= 0;
    md <= 8'hc0;
    mlast <= 1'b1;
    mv <= 1'b1;
    i2c_start(8'h4b, 1'b1);
    i2c_rd(8'h14);
    i2c_start(8'h4a, 1'b1);
    i2c_wr(I2C_STREAM_ADDR);
    i2c_start(8'h4b, 1'b1);
    i2c_rd(8'hc0);
    `CHK(mv, 1'b0)
    i2c_rd(8'h00);
    $display("test i2c map done");
    close_out();
  end
endmodule : tb_touch_report_framer
